// ===== sdcd_consts.svh
// Constant macros for the command decoder: bit positions, widths, defaults
`ifndef SDCD_CONSTS_SVH
`define SDCD_CONSTS_SVH

// ****************************************************************
// Bus widths
// ****************************************************************
`define SDCD_ADDR_W 12
`define SDCD_DQ_W 16
`define SDCD_ROW_W 11
`define SDCD_COL_W 8

// ****************************************************************
// Address field positions
// ****************************************************************
`define SDCD_BANK_BIT 11
`define SDCD_A10_BIT 10
`define SDCD_ROW_MSB 10
`define SDCD_COL_MSB 7

// ****************************************************************
// Data lanes and timing
// ****************************************************************
`define SDCD_HI_LANE_LSB 8
`define SDCD_READ_MASK_LAT 2
`define SDCD_PAGE_COLS 256
`define SDCD_BURST_LEN_DEF 4

`endif

// ===== sdcd_pkg.sv
// Types shared by both ends of the command bus
package sdcd_pkg;

  // ****************************************************************
  // Command and power state types
  // ****************************************************************
  typedef enum logic [3:0] {
    sdcd_cmd_deselect,
    sdcd_cmd_nop,
    sdcd_cmd_open_row,
    sdcd_cmd_close,
    sdcd_cmd_read,
    sdcd_cmd_write,
    sdcd_cmd_mode_set,
    sdcd_cmd_burst_stop,
    sdcd_cmd_refresh
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    sdcd_pw_run,
    sdcd_pw_suspend,
    sdcd_pw_power_down,
    sdcd_pw_self_refresh
  } sdcd_power_t;

  // Strobe pattern to command, chip select high wins over all
  function automatic sdcd_cmd_t sdcd_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    sdcd_cmd_t c;
    c = sdcd_cmd_nop;
    if (cs_n) begin
      c = sdcd_cmd_deselect;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h3: c = sdcd_cmd_open_row;
        3'h2: c = sdcd_cmd_close;
        3'h5: c = sdcd_cmd_read;
        3'h4: c = sdcd_cmd_write;
        3'h0: c = sdcd_cmd_mode_set;
        3'h1: c = sdcd_cmd_refresh;
        3'h6: c = sdcd_cmd_burst_stop;
        3'h7: c = sdcd_cmd_nop;
      endcase
    end
    return c;
  endfunction : sdcd_decode

endpackage : sdcd_pkg

// ===== sdcd_bus_if.sv
// Interface joining the memory controller end and the memory device end
`timescale 1ns/100ps
`default_nettype none
`include "sdcd_consts.svh"
interface sdcd_bus_if;
  // Command pins, driven by the controller
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`SDCD_ADDR_W-1:0] addr;
  logic cke;
  logic high_byte_mask;
  logic low_byte_mask;
  // Data pins, split per driver and per byte lane
  logic [`SDCD_DQ_W-1:0] dq_host;
  logic [1:0] dq_host_oe;
  logic [`SDCD_DQ_W-1:0] dq_dev;
  logic [1:0] dq_dev_oe;
  logic [`SDCD_DQ_W-1:0] dq_wire;

  // Wire level per lane; an undriven lane reads as zero
  assign dq_wire[7:0] = dq_host_oe[0] ? dq_host[7:0] : (dq_dev_oe[0] ? dq_dev[7:0] : 8'h00);
  assign dq_wire[15:8] = dq_host_oe[1] ? dq_host[15:8] : (dq_dev_oe[1] ? dq_dev[15:8] : 8'h00);

  modport device (
    input cs_n, ras_n, cas_n, we_n, addr, cke, high_byte_mask, low_byte_mask, dq_wire,
    output dq_dev, dq_dev_oe
  );
  modport host (
    output cs_n, ras_n, cas_n, we_n, addr, cke, high_byte_mask, low_byte_mask, dq_host,
    output dq_host_oe,
    input dq_wire, dq_dev_oe
  );
endinterface : sdcd_bus_if
`default_nettype wire

// ===== sdcd_device.sv
// Memory device end: command decode, bank state, bursts and byte masking
// Notes on behaviour
// - High byte mask turns that lane's drivers off
// - Masked write lanes leave memory byte unchanged
// - Read mask suppresses output two clocks later
// - High mask bits 15:8, low mask 7:0
// - Mask acts per sample, per lane only
// - Data sampled and driven on rising edges
// - All command pins latched each rising edge
// - Decode strobes into commands, A10 selects all
// - Open row idle bank; access open bank only
// - Burst stop ends a running burst only
// - Commands need previous clock enable high
// - Refresh code: auto or self by enable
// - Enable falling with open bank, command not quiet: clock suspend
// - Enable rising leaves suspend, resumes operation
// - Enable falling with no-op enters power down
// - Enable rising with no-op leaves power down
// - Power down during burst becomes suspend
// - Address bit 11 picks the bank
// - Column bits 7:0, A10 requests auto precharge
// - Chip select high ignores the command
`timescale 1ns/100ps
`default_nettype none
`include "sdcd_consts.svh"
module sdcd_device #(
  parameter int BURST_LEN = `SDCD_BURST_LEN_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  sdcd_bus_if.device bus,
  output logic acc_wr,
  output logic acc_rd,
  output logic acc_bank,
  output logic [`SDCD_ROW_W-1:0] acc_row,
  output logic [`SDCD_COL_W-1:0] acc_col,
  output logic [`SDCD_DQ_W-1:0] acc_wdata,
  output logic [1:0] acc_byte_en,
  input wire logic [`SDCD_DQ_W-1:0] rd_data,
  output logic [1:0] bank_open,
  output logic burst_busy,
  output sdcd_pkg::sdcd_power_t power_state,
  output logic refresh_pulse,
  output logic mode_load,
  output logic [`SDCD_ADDR_W-1:0] mode_word
);
  import sdcd_pkg::*;
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  localparam bit FULL_PAGE = (BURST_LEN == `SDCD_PAGE_COLS);
  localparam int LW = 9;
  if (!(BURST_LEN inside {1, 2, 4, 8, `SDCD_PAGE_COLS})) begin : g_len_check
    $error("BURST_LEN must be 1, 2, 4, 8 or a full page");
  end
  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic s_cs_n, s_ras_n, s_cas_n, s_we_n; // Sampled strobes
  logic [`SDCD_ADDR_W-1:0] s_addr; // Sampled address
  logic s_cke, cke_prev; // Clock enable now and one cycle earlier
  logic [1:0] s_mask, mask_d; // Masks now and one cycle old, bit 1 high lane
  logic [`SDCD_DQ_W-1:0] s_dq; // Sampled data wire
  // Every pin is captured on each rising edge, reset leaves deselect
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {s_cs_n, s_ras_n, s_cas_n, s_we_n} <= 4'hF;
      s_addr <= 12'h000;
      {s_cke, cke_prev} <= 2'h3;
      {s_mask, mask_d} <= 4'hF;
      s_dq <= 16'h0000;
    end else begin
      {s_cs_n, s_ras_n, s_cas_n, s_we_n} <= {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
      s_addr <= bus.addr;
      s_cke <= bus.cke;
      cke_prev <= s_cke;
      s_mask <= {bus.high_byte_mask, bus.low_byte_mask};
      mask_d <= s_mask;
      s_dq <= bus.dq_wire;
    end
  end
  // ****************************************************************
  // Decode and state
  // ****************************************************************
  sdcd_cmd_t cmd; // Decoded command of the sampled cycle
  logic bsel; // Bank named by the sampled address
  logic [`SDCD_ROW_W-1:0] row [2]; // Open row of each bank
  logic burst_rd, burst_bank, burst_ap; // Burst is a read, its bank, close at end
  logic [`SDCD_COL_W-1:0] burst_col; // Next column of the burst
  logic [LW-1:0] burst_left; // Beats still to issue
  logic [`SDCD_DQ_W-1:0] dq_out; // Registered read data
  logic [1:0] dq_oe; // Registered lane drive enables
  logic next_acc_wr, next_acc_rd, next_acc_bank;
  logic [`SDCD_ROW_W-1:0] next_acc_row;
  logic [`SDCD_COL_W-1:0] next_acc_col;
  logic [`SDCD_DQ_W-1:0] next_acc_wdata;
  logic [1:0] next_acc_byte_en, next_bank_open, next_dq_oe;
  logic next_burst_busy, next_burst_rd, next_burst_bank, next_burst_ap;
  logic [`SDCD_COL_W-1:0] next_burst_col;
  logic [LW-1:0] next_burst_left;
  logic [`SDCD_ROW_W-1:0] next_row [2];
  sdcd_power_t next_power_state;
  logic next_refresh_pulse, next_mode_load;
  logic [`SDCD_ADDR_W-1:0] next_mode_word;
  logic [`SDCD_DQ_W-1:0] next_dq_out;
  logic advance; // Internal clock live this cycle
  logic exec; // Ordinary command may be taken
  logic idle_all; // No bank open and no burst
  logic quiet; // Deselect or no-op on the pins
  assign cmd = sdcd_decode(s_cs_n, s_ras_n, s_cas_n, s_we_n);
  assign bsel = s_addr[`SDCD_BANK_BIT];
  assign advance = (power_state == sdcd_pw_run);
  assign exec = advance && cke_prev && s_cke;
  assign idle_all = (bank_open == 2'h0) && !burst_busy;
  assign quiet = (cmd == sdcd_cmd_deselect) || (cmd == sdcd_cmd_nop);
  // Next values of the whole device; later branches override earlier ones
  always_comb begin
    next_acc_wr = 1'b0;
    next_acc_rd = advance ? 1'b0 : acc_rd; // Frozen read repeats, which is harmless
    next_acc_bank = acc_bank;
    next_acc_row = acc_row;
    next_acc_col = acc_col;
    next_acc_wdata = s_dq;
    next_acc_byte_en = ~s_mask;
    next_bank_open = bank_open;
    next_burst_busy = burst_busy;
    next_burst_rd = burst_rd;
    next_burst_bank = burst_bank;
    next_burst_ap = burst_ap;
    next_burst_col = burst_col;
    next_burst_left = burst_left;
    next_row = row;
    next_power_state = power_state;
    next_refresh_pulse = 1'b0;
    next_mode_load = 1'b0;
    next_mode_word = mode_word;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    // Continue a running burst while the clock is live
    if (advance && burst_busy) begin
      next_acc_wr = !burst_rd;
      next_acc_rd = burst_rd;
      next_acc_bank = burst_bank;
      next_acc_row = row[burst_bank];
      next_acc_col = burst_col;
      next_burst_col = 8'(burst_col + 8'h01); // Full page wraps to column 0
      if (!FULL_PAGE) begin
        next_burst_left = LW'(burst_left - 9'h001);
        if (burst_left == 9'h001) begin
          next_burst_busy = 1'b0;
          if (burst_ap) next_bank_open[burst_bank] = 1'b0;
        end
      end
    end
    // Ordinary commands; read or write to an open bank, burst stop and a close of its bank or of all banks interrupt a running burst
    if (exec) begin
      unique case (cmd)
        sdcd_cmd_open_row: begin
          if (!bank_open[bsel]) begin
            next_bank_open[bsel] = 1'b1;
            next_row[bsel] = s_addr[`SDCD_ROW_MSB:0];
          end
        end
        sdcd_cmd_close: begin
          next_bank_open[bsel] = 1'b0;
          if (s_addr[`SDCD_A10_BIT]) begin
            next_bank_open = 2'h0;
          end
          if (s_addr[`SDCD_A10_BIT] || (burst_bank == bsel)) begin
            next_burst_busy = 1'b0;
          end
        end
        sdcd_cmd_read, sdcd_cmd_write: begin
          if (bank_open[bsel]) begin
            next_acc_wr = (cmd == sdcd_cmd_write);
            next_acc_rd = (cmd == sdcd_cmd_read);
            next_acc_bank = bsel;
            next_acc_row = row[bsel];
            next_acc_col = s_addr[`SDCD_COL_MSB:0];
            next_burst_rd = (cmd == sdcd_cmd_read);
            next_burst_bank = bsel;
            next_burst_ap = s_addr[`SDCD_A10_BIT] && !FULL_PAGE;
            next_burst_col = 8'(s_addr[`SDCD_COL_MSB:0] + 8'h01);
            next_burst_left = LW'(BURST_LEN - 1);
            next_burst_busy = (BURST_LEN > 1);
            if ((BURST_LEN == 1) && s_addr[`SDCD_A10_BIT]) begin
              next_bank_open[bsel] = 1'b0;
            end
          end
        end
        sdcd_cmd_mode_set: begin
          if (idle_all) begin
            next_mode_load = 1'b1;
            next_mode_word = s_addr;
          end
        end
        sdcd_cmd_burst_stop: next_burst_busy = 1'b0;
        sdcd_cmd_refresh: next_refresh_pulse = idle_all;
        sdcd_cmd_deselect, sdcd_cmd_nop: ;
      endcase
    end
    // Clock enable transitions
    unique case (power_state)
      sdcd_pw_run: begin
        if (cke_prev && !s_cke) begin
          if ((cmd == sdcd_cmd_refresh) && idle_all) begin
            next_power_state = sdcd_pw_self_refresh;
          end else if (burst_busy) begin
            next_power_state = sdcd_pw_suspend;
          end else if (quiet) begin
            next_power_state = sdcd_pw_power_down;
          end else if (bank_open != 2'h0) begin
            next_power_state = sdcd_pw_suspend;
          end
        end
      end
      sdcd_pw_suspend: if (!cke_prev && s_cke) next_power_state = sdcd_pw_run;
      sdcd_pw_power_down, sdcd_pw_self_refresh: begin
        if (!cke_prev && s_cke && quiet) next_power_state = sdcd_pw_run;
      end
    endcase
    // Read data leaves two edges after the mask that governs it
    if (advance) begin
      next_dq_out = rd_data;
      next_dq_oe = {acc_rd, acc_rd} & ~mask_d;
    end
  end
  // Registers of the device state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {acc_wr, acc_rd, acc_bank} <= 3'h0;
      acc_row <= 11'h000;
      acc_col <= 8'h00;
      acc_wdata <= 16'h0000;
      acc_byte_en <= 2'h0;
      {bank_open, burst_busy} <= 3'h0;
      {burst_rd, burst_bank, burst_ap} <= 3'h0;
      burst_col <= 8'h00;
      burst_left <= 9'h000;
      row <= '{default: 11'h000};
      power_state <= sdcd_pw_run;
      {refresh_pulse, mode_load} <= 2'h0;
      mode_word <= 12'h000;
      dq_out <= 16'h0000;
      dq_oe <= 2'h0;
    end else begin
      {acc_wr, acc_rd, acc_bank} <= {next_acc_wr, next_acc_rd, next_acc_bank};
      acc_row <= next_acc_row;
      acc_col <= next_acc_col;
      acc_wdata <= next_acc_wdata;
      acc_byte_en <= next_acc_byte_en;
      {bank_open, burst_busy} <= {next_bank_open, next_burst_busy};
      {burst_rd, burst_bank, burst_ap} <= {next_burst_rd, next_burst_bank, next_burst_ap};
      burst_col <= next_burst_col;
      burst_left <= next_burst_left;
      row <= next_row;
      power_state <= next_power_state;
      {refresh_pulse, mode_load} <= {next_refresh_pulse, next_mode_load};
      mode_word <= next_mode_word;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
    end
  end
  assign bus.dq_dev = dq_out;
  assign bus.dq_dev_oe = dq_oe;
endmodule : sdcd_device
`default_nettype wire

// ===== sdcd_host.sv
// Memory controller end: encodes user commands onto the bus and guards legality
`timescale 1ns/100ps
`default_nettype none
`include "sdcd_consts.svh"
module sdcd_host #(
  parameter int BURST_LEN = `SDCD_BURST_LEN_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  sdcd_bus_if.host bus,
  input wire sdcd_pkg::sdcd_cmd_t req_cmd,
  input wire logic [`SDCD_ADDR_W-1:0] req_addr,
  input wire logic req_cke,
  input wire logic [1:0] req_mask,
  input wire logic [`SDCD_DQ_W-1:0] req_wdata,
  input wire logic req_wdata_en,
  output logic [`SDCD_DQ_W-1:0] rd_data,
  output logic [1:0] rd_lane_valid,
  output logic cmd_refused
);
  import sdcd_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial begin
    if (!(BURST_LEN inside {1, 2, 4, 8, `SDCD_PAGE_COLS})) begin
      $error("BURST_LEN must be 1, 2, 4, 8 or a full page");
    end
  end

  // ****************************************************************
  // Shadow state and bus registers
  // ****************************************************************
  logic [1:0] open_shadow; // Banks believed open
  logic [8:0] beats_left; // Burst beats believed still running
  logic [3:0] strobes, next_strobes; // cs, ras, cas, we, all active low
  logic [`SDCD_ADDR_W-1:0] addr_q, next_addr_q;
  logic cke_q, next_cke_q;
  logic [1:0] mask_q, next_mask_q, wd_oe, next_wd_oe;
  logic [`SDCD_DQ_W-1:0] wd_q, next_wd_q;
  logic [1:0] next_open_shadow;
  logic [8:0] next_beats_left;
  logic next_cmd_refused;
  logic [`SDCD_DQ_W-1:0] next_rd_data;
  logic [1:0] next_rd_lane_valid;
  logic ok; // Request is legal in the shadow state
  logic b; // Bank of the request

  assign b = req_addr[`SDCD_BANK_BIT];

  // Legality check, then the strobe pattern of the command
  always_comb begin
    ok = 1'b1;
    unique case (req_cmd)
      sdcd_cmd_open_row: ok = !open_shadow[b];
      sdcd_cmd_read, sdcd_cmd_write: ok = open_shadow[b];
      sdcd_cmd_mode_set, sdcd_cmd_refresh: ok = (open_shadow == 2'h0);
      sdcd_cmd_burst_stop: ok = (beats_left != 9'h000);
      default: ok = 1'b1;
    endcase
    // Enable edges carry only a no-op or deselect, so power down stays clean
    if (req_cke != cke_q) begin
      ok = (req_cmd == sdcd_cmd_nop) || (req_cmd == sdcd_cmd_deselect);
    end
    next_cmd_refused = !ok;
    next_strobes = 4'h7; // No-op
    next_open_shadow = open_shadow;
    next_beats_left = (beats_left != 9'h000) ? 9'(beats_left - 9'h001) : 9'h000;
    if (!cke_q) begin
      next_beats_left = beats_left; // Burst frozen while enable is low
    end
    if (ok) begin
      unique case (req_cmd)
        sdcd_cmd_deselect: next_strobes = 4'hF;
        sdcd_cmd_nop: next_strobes = 4'h7;
        sdcd_cmd_open_row: begin
          next_strobes = 4'h3;
          next_open_shadow[b] = 1'b1;
        end
        sdcd_cmd_close: begin
          next_strobes = 4'h2;
          next_beats_left = 9'h000;
          if (req_addr[`SDCD_A10_BIT]) begin
            next_open_shadow = 2'h0;
          end else begin
            next_open_shadow[b] = 1'b0;
          end
        end
        sdcd_cmd_read, sdcd_cmd_write: begin
          next_strobes = (req_cmd == sdcd_cmd_read) ? 4'h5 : 4'h4;
          next_beats_left = 9'(BURST_LEN - 1);
          if (req_addr[`SDCD_A10_BIT] && (BURST_LEN != `SDCD_PAGE_COLS)) begin
            next_open_shadow[b] = 1'b0; // Auto precharge closes it
          end
        end
        sdcd_cmd_mode_set: next_strobes = 4'h0;
        sdcd_cmd_burst_stop: begin
          next_strobes = 4'h6;
          next_beats_left = 9'h000;
        end
        sdcd_cmd_refresh: next_strobes = 4'h1;
      endcase
    end
    next_addr_q = req_addr;
    next_cke_q = req_cke;
    next_mask_q = req_mask;
    next_wd_q = req_wdata;
    next_wd_oe = {req_wdata_en, req_wdata_en};
    next_rd_data = bus.dq_wire;
    next_rd_lane_valid = bus.dq_dev_oe;
  end

  // Registers of the controller end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      strobes <= 4'hF;
      addr_q <= 12'h000;
      cke_q <= 1'b1;
      mask_q <= 2'h3;
      wd_q <= 16'h0000;
      wd_oe <= 2'h0;
      open_shadow <= 2'h0;
      beats_left <= 9'h000;
      cmd_refused <= 1'b0;
      rd_data <= 16'h0000;
      rd_lane_valid <= 2'h0;
    end else begin
      strobes <= next_strobes;
      addr_q <= next_addr_q;
      cke_q <= next_cke_q;
      mask_q <= next_mask_q;
      wd_q <= next_wd_q;
      wd_oe <= next_wd_oe;
      open_shadow <= next_open_shadow;
      beats_left <= next_beats_left;
      cmd_refused <= next_cmd_refused;
      rd_data <= next_rd_data;
      rd_lane_valid <= next_rd_lane_valid;
    end
  end

  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = strobes;
  assign bus.addr = addr_q;
  assign bus.cke = cke_q;
  assign {bus.high_byte_mask, bus.low_byte_mask} = mask_q;
  assign bus.dq_host = wd_q;
  assign bus.dq_host_oe = wd_oe;
endmodule : sdcd_host
`default_nettype wire

// ===== sdcd_monitor.sv
// Checker on the bus signals joining controller end and memory end
`timescale 1ns/100ps
`default_nettype none
module sdcd_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic cke,
  input wire logic high_byte_mask,
  input wire logic low_byte_mask,
  input wire logic [1:0] dq_host_oe,
  input wire logic [1:0] dq_dev_oe
);
  // ****
  // Bank shadow
  // ****
  logic rd; // Read code on pins
  logic wr; // Write code on pins
  logic [1:0] open_b; // Banks seen opened
  logic [1:0] next_open_b;
  logic cke_d; // Enable one tick back
  logic next_cke_d;
  assign rd = !cs_n && ras_n && !cas_n && we_n;
  assign wr = !cs_n && ras_n && !cas_n && !we_n;
  // Only open and close tracked; refusals would make this optimistic
  always_comb begin
    next_open_b = open_b;
    next_cke_d = cke;
    if (!cs_n && !ras_n && cas_n && cke && cke_d) begin
      if (we_n) begin
        next_open_b[addr[11]] = 1'b1;
      end else if (addr[10]) begin
        next_open_b = 2'h0;
      end else begin
        next_open_b[addr[11]] = 1'b0;
      end
    end
  end
  // Registers only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      open_b <= 2'h0;
      cke_d <= 1'b1;
    end else begin
      open_b <= next_open_b;
      cke_d <= next_cke_d;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_hi_mask;
    cke && cke_d && high_byte_mask ##1 cke [*2] |=> !dq_dev_oe[1];
  endproperty
  a_hi_mask: assert property (p_hi_mask) else $error("upper lane driven");
  property p_lo_mask;
    cke && cke_d && low_byte_mask ##1 cke [*2] |=> !dq_dev_oe[0];
  endproperty
  a_lo_mask: assert property (p_lo_mask) else $error("lower lane driven");
  property p_rd_lat;
    rd && open_b[addr[11]] && cke && cke_d && $past(cke_d) && !low_byte_mask
      ##1 cke [*2] |=> dq_dev_oe[0];
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_wr_quiet;
    wr && cke && cke_d ##1 cke [*2] |=> dq_dev_oe == 2'h0;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("driven on write");
  property p_sus_hold;
    !cke [*3] |=> $stable(dq_dev_oe);
  endproperty
  a_sus_hold: assert property (p_sus_hold) else $error("output moved");
  property p_reset_idle;
    $rose(nrst) |-> (dq_dev_oe == 2'h0) [*3];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("driven at start");
  property p_cke_cmd;
    $changed(cke) |-> cs_n || (ras_n && cas_n && we_n);
  endproperty
  a_cke_cmd: assert property (p_cke_cmd) else $error("command at cke edge");
  property p_no_clash;
    (dq_host_oe & dq_dev_oe) == 2'h0;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("lane contention");
  c_read: cover property (rd && open_b != 2'h0);
  c_susp: cover property (!cke [*3]);
  c_mask: cover property (high_byte_mask && !low_byte_mask);
endmodule : sdcd_monitor
`default_nettype wire

// ===== sdram_command_decode_and_mask_test.sv
// Bench joining both ends, with a byte store behind the device
`timescale 1ns/100ps
`default_nettype none
module sdram_command_decode_and_mask_test;
  import sdcd_pkg::*;
  logic ref_clk = 1'b0; // 20 MHz
  logic nrst = 1'b0;
  sdcd_cmd_t req_cmd = sdcd_cmd_nop;
  logic [11:0] req_addr = 12'h000;
  logic ck = 1'b1; // Enable level for coming requests
  logic req_cke = 1'b1;
  logic [1:0] req_mask = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic req_wdata_en = 1'b0;
  logic [15:0] host_rd;
  logic [1:0] rd_lane_valid;
  logic refused;
  logic acc_wr;
  logic [7:0] acc_col;
  logic [15:0] acc_wdata;
  logic [1:0] acc_byte_en;
  logic [15:0] mem_rd;
  logic [1:0] bank_open;
  logic burst_busy;
  sdcd_power_t power_state;
  logic refresh_pulse;
  logic mode_load;
  logic [11:0] mode_word;
  logic [15:0] mem [256]; // Bank bits ignored: one row is enough here
  logic [15:0] wd [4] = '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0789};
  logic [1:0] wm [4] = '{2'h0, 2'h2, 2'h1, 2'h0}; // Write beat masks
  logic [1:0] rm [4] = '{2'h0, 2'h3, 2'h2, 2'h0}; // Read beat masks
  int fails = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  sdcd_bus_if u_sdcd_bus_if ();
  sdcd_host #(.BURST_LEN(4)) u_sdcd_host (.ref_clk(ref_clk), .nrst(nrst), .bus(u_sdcd_bus_if),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_cke(req_cke), .req_mask(req_mask),
    .req_wdata(req_wdata), .req_wdata_en(req_wdata_en), .rd_data(host_rd),
    .rd_lane_valid(rd_lane_valid), .cmd_refused(refused));
  sdcd_device #(.BURST_LEN(4)) u_sdcd_device (.ref_clk(ref_clk), .nrst(nrst),
    .bus(u_sdcd_bus_if), .acc_wr(acc_wr), .acc_rd(), .acc_bank(), .acc_row(), .acc_col(acc_col),
    .acc_wdata(acc_wdata), .acc_byte_en(acc_byte_en), .rd_data(mem_rd), .bank_open(bank_open),
    .burst_busy(burst_busy), .power_state(power_state), .refresh_pulse(refresh_pulse),
    .mode_load(mode_load), .mode_word(mode_word));
  sdcd_monitor u_sdcd_monitor (.ref_clk(ref_clk), .nrst(nrst), .cs_n(u_sdcd_bus_if.cs_n),
    .ras_n(u_sdcd_bus_if.ras_n), .cas_n(u_sdcd_bus_if.cas_n), .we_n(u_sdcd_bus_if.we_n),
    .addr(u_sdcd_bus_if.addr), .cke(u_sdcd_bus_if.cke),
    .high_byte_mask(u_sdcd_bus_if.high_byte_mask), .low_byte_mask(u_sdcd_bus_if.low_byte_mask),
    .dq_host_oe(u_sdcd_bus_if.dq_host_oe), .dq_dev_oe(u_sdcd_bus_if.dq_dev_oe));
  assign mem_rd = mem[acc_col];
  // Byte-enabled store of written beats
  always @(posedge ref_clk) begin
    if (acc_wr && acc_byte_en[0]) begin
      mem[acc_col][7:0] <= acc_wdata[7:0];
    end
    if (acc_wr && acc_byte_en[1]) begin
      mem[acc_col][15:8] <= acc_wdata[15:8];
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic go(input sdcd_cmd_t c, input logic [11:0] a, input logic [1:0] m,
      input logic [15:0] d = 16'h0000, input logic e = 1'b0);
    @(posedge ref_clk);
    req_cmd <= c;
    req_addr <= a;
    req_mask <= m;
    req_wdata <= d;
    req_wdata_en <= e;
    req_cke <= ck;
  endtask : go
  task automatic nops(input int n);
    repeat (n) go(sdcd_cmd_nop, 12'h000, 2'h0);
    #1;
  endtask : nops
  task automatic chk(input logic [17:0] g, input logic [17:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // ****
  // Scenarios
  // ****
  task automatic t_idle();
    go(sdcd_cmd_refresh, 12'h000, 2'h0);
    nops(3);
    chk({17'h00000, refresh_pulse}, 18'h00001);
    go(sdcd_cmd_mode_set, 12'h023, 2'h0);
    nops(3);
    chk({5'h00, mode_load, mode_word}, {5'h00, 1'b1, 12'h023});
  endtask : t_idle
  task automatic t_open();
    go(sdcd_cmd_open_row, 12'h805, 2'h0);
    nops(4);
    chk({16'h0000, bank_open}, 18'h00002);
    go(sdcd_cmd_open_row, 12'h005, 2'h0);
    nops(4);
    chk({16'h0000, bank_open}, 18'h00003);
    go(sdcd_cmd_open_row, 12'h005, 2'h0);
    nops(1);
    chk({17'h00000, refused}, 18'h00001);
  endtask : t_open
  task automatic t_write();
    for (int i = 0; i < 4; i++) begin
      go(i == 0 ? sdcd_cmd_write : sdcd_cmd_nop, 12'h008, wm[i], wd[i], 1'b1);
    end
    nops(5);
    chk({2'h0, mem[8]}, {2'h0, 16'hA1B2});
    chk({2'h0, mem[10]}, {2'h0, 16'hE500});
  endtask : t_write
  task automatic t_read();
    logic [17:0] got [4];
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      go(i == 0 ? sdcd_cmd_read : sdcd_cmd_nop, 12'h008, rm[i]);
    end
    for (int i = 0; i < 12 && n < 4; i++) begin
      @(posedge ref_clk);
      #1;
      if (n > 0 || rd_lane_valid != 2'h0) begin
        got[n] = {rd_lane_valid, host_rd};
        n++;
      end
    end
    if (n < 4) begin
      fails++;
      stop_test();
    end
    chk(got[0], {2'h3, 16'hA1B2});
    chk(got[1], 18'h00000);
    chk(got[2], {2'h1, 16'h0000});
    chk(got[3], {2'h3, 16'h0789});
  endtask : t_read
  task automatic t_close();
    go(sdcd_cmd_close, 12'h800, 2'h0);
    nops(4);
    chk({16'h0000, bank_open}, 18'h00001);
    go(sdcd_cmd_close, 12'h400, 2'h0);
    nops(4);
    chk({16'h0000, bank_open}, 18'h00000);
  endtask : t_close
  task automatic t_power();
    ck = 1'b0;
    nops(6);
    chk({16'h0000, power_state}, {16'h0000, sdcd_pw_power_down});
    ck = 1'b1;
    nops(6);
    chk({16'h0000, power_state}, {16'h0000, sdcd_pw_run});
  endtask : t_power
  task automatic t_suspend();
    go(sdcd_cmd_open_row, 12'h000, 2'h0);
    nops(3);
    go(sdcd_cmd_read, 12'h010, 2'h0);
    ck = 1'b0;
    nops(6);
    chk({16'h0000, power_state}, {16'h0000, sdcd_pw_suspend});
    ck = 1'b1;
    nops(6);
    chk({16'h0000, power_state}, {16'h0000, sdcd_pw_run});
  endtask : t_suspend
  task automatic t_stop();
    go(sdcd_cmd_read, 12'h008, 2'h0);
    go(sdcd_cmd_burst_stop, 12'h000, 2'h0);
    nops(2);
    chk({17'h00000, burst_busy}, 18'h00001);
    nops(1);
    chk({17'h00000, burst_busy}, 18'h00000);
  endtask : t_stop
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_idle();
    t_open();
    t_write();
    t_read();
    t_close();
    t_power();
    t_suspend();
    t_stop();
    stop_test();
  end
endmodule : sdram_command_decode_and_mask_test
`default_nettype wire
